// File: tb/pfcr_mgr_model.sv
`timescale 1ns/1ps
// ****
// port manager side: register strobes and the alert flag write
// ****
module pfcr_mgr_model (
  // clock
  input wire logic clk,
  // register strobes
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  // alert register written with one in the fault bit
  output logic alert_wr1
);
  initial begin
    {addr, wdata, wr, rd, alert_wr1} = '0;
  end
  // one strobe cycle; on release the strobes drop and address and data are inverted so stale values never pass
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  // pending faults first, the alert flag only once they are gone
  task automatic clear_all(input logic [7:0] bits);
    acc(1'b1, 8'h1f, bits);
    @(negedge clk);
    alert_wr1 = 1'b1;
    @(negedge clk);
    alert_wr1 = 1'b0;
  endtask
endmodule

// File: tb/pfcr_regs_monitor.sv
`timescale 1ns/1ps
// ****
// port checks of the fault, command and capability registers
// ****
module pfcr_regs_monitor #(
  parameter int SAFE_ZERO_CNT = pfcr_pkg::SAFE_ZERO_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic [pfcr_pkg::REG_W-1:0] REG_ADDR,
  input wire logic [pfcr_pkg::REG_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [pfcr_pkg::REG_W-1:0] REG_RDATA,
  input wire logic REG_RVALID,
  // neighbouring control and fault source
  input wire logic ALERT_MASK_FAULT,
  input wire logic ALERT_FAULT_WR1,
  input wire logic ROLE_DRP,
  input wire logic [1:0] ROLE_CC1,
  input wire logic [1:0] ROLE_CC2,
  input wire logic CABLE_POWER_OVERCURRENT,
  // flag, interrupt and seek outputs
  input wire logic ALERT_FAULT,
  input wire logic INT_N_OE,
  input wire logic SEEK_START,
  input wire logic SEEK_START_PULLUP
);
  import pfcr_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  rd_answer_a:
    assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
  cap_value_a:
    assert property (REG_RD && REG_ADDR == 8'h24 |=> REG_RDATA == 8'hd8)
    else $error("capability byte wrong");
  cmd_idle_a:
    assert property (REG_RD && REG_ADDR == 8'h23 && !REG_WR && !$past(REG_WR)
      && !$past(REG_WR, 2) |=> REG_RDATA == 8'h00) else $error("command not cleared");
  seek_go_a:
    assert property ((REG_WR && REG_ADDR == 8'h23 && REG_WDATA == 8'h99 && ROLE_DRP
      && ROLE_CC1 == ROLE_CC2 && ROLE_CC1 inside {2'h1, 2'h2}) ##1
      (!REG_WR && $stable({ROLE_DRP, ROLE_CC1, ROLE_CC2}))
      |=> SEEK_START && SEEK_START_PULLUP == (ROLE_CC1 == 2'h1)) else $error("seek missed");
  seek_cause_a:
    assert property (SEEK_START |-> $past(REG_WR, 2) && $past(REG_ADDR, 2) == 8'h23
      && $past(REG_WDATA, 2) == 8'h99 && $past(ROLE_DRP) && $past(ROLE_CC1) == $past(ROLE_CC2))
    else $error("seek without cause");
  fault_alert_a:
    assert property ($rose(CABLE_POWER_OVERCURRENT) |=> ALERT_FAULT)
    else $error("overcurrent not flagged");
  alert_hold_a:
    assert property (ALERT_FAULT && !ALERT_FAULT_WR1 |=> ALERT_FAULT)
    else $error("alert flag lost");
  int_gate_a:
    assert property (INT_N_OE |-> $past(ALERT_MASK_FAULT) && $past(ALERT_FAULT))
    else $error("interrupt while masked");
  int_release_a:
    assert property (!ALERT_FAULT |=> !INT_N_OE) else $error("interrupt not released");
  cover property (SEEK_START && SEEK_START_PULLUP);
  cover property (SEEK_START && !SEEK_START_PULLUP);
  cover property ($fell(INT_N_OE));
endmodule

bind pfcr_regs pfcr_regs_monitor #(.SAFE_ZERO_CNT(SAFE_ZERO_CNT)) u_mon (
  .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .ALERT_MASK_FAULT(ALERT_MASK_FAULT), .ALERT_FAULT_WR1(ALERT_FAULT_WR1),
  .ROLE_DRP(ROLE_DRP), .ROLE_CC1(ROLE_CC1), .ROLE_CC2(ROLE_CC2),
  .CABLE_POWER_OVERCURRENT(CABLE_POWER_OVERCURRENT), .ALERT_FAULT(ALERT_FAULT),
  .INT_N_OE(INT_N_OE), .SEEK_START(SEEK_START), .SEEK_START_PULLUP(SEEK_START_PULLUP));

// File: tb/tb.sv
`timescale 1ns/1ps
// ****
// bench of the fault, command and capability registers
// ****
module tb;
  import pfcr_pkg::*;
  localparam int SZ = 20;
  logic CLK, RST_N, REG_WR, REG_RD, REG_RVALID, ALERT_MASK_FAULT, ALERT_FAULT_WR1, ROLE_DRP;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, FAULT_MASK, code, e;
  logic [1:0] ROLE_CC1, ROLE_CC2;
  logic AUTO_DRAIN_ON_DETACH, FORCED_DRAIN, VBUS_BELOW_SAFE_ZERO, CABLE_POWER_OVERCURRENT;
  logic TX_REQUEST, TX_BUF_EMPTY, RSVD_BIT_WRITE, DEFAULTS_RESTORED, ATTACH_FOUND;
  logic ALERT_FAULT, INT_N_O, INT_N_OE, SEEK_START, SEEK_ACTIVE, SEEK_START_PULLUP;
  int n_errors, checked;
  logic [7:0] exp_q[$];
  // open-drain pin with its pull-up
  wire int_n = INT_N_OE ? INT_N_O : 1'b1;
  pfcr_regs #(.SAFE_ZERO_CNT(SZ)) dut (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .FAULT_MASK(FAULT_MASK), .ALERT_MASK_FAULT(ALERT_MASK_FAULT),
    .ALERT_FAULT_WR1(ALERT_FAULT_WR1), .ROLE_DRP(ROLE_DRP), .ROLE_CC1(ROLE_CC1),
    .ROLE_CC2(ROLE_CC2), .AUTO_DRAIN_ON_DETACH(AUTO_DRAIN_ON_DETACH),
    .FORCED_DRAIN(FORCED_DRAIN), .VBUS_BELOW_SAFE_ZERO(VBUS_BELOW_SAFE_ZERO),
    .CABLE_POWER_OVERCURRENT(CABLE_POWER_OVERCURRENT), .TX_REQUEST(TX_REQUEST),
    .TX_BUF_EMPTY(TX_BUF_EMPTY), .RSVD_BIT_WRITE(RSVD_BIT_WRITE),
    .DEFAULTS_RESTORED(DEFAULTS_RESTORED), .ATTACH_FOUND(ATTACH_FOUND),
    .ALERT_FAULT(ALERT_FAULT), .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE),
    .SEEK_START(SEEK_START), .SEEK_ACTIVE(SEEK_ACTIVE), .SEEK_START_PULLUP(SEEK_START_PULLUP));
  pfcr_mgr_model mgr (.clk(CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR),
    .rd(REG_RD), .alert_wr1(ALERT_FAULT_WR1));
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask
  // the expectation is queued before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    mgr.acc(1'b0, a, 8'h00);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // each read answer is matched to the oldest queued expectation
  always @(negedge CLK) begin
    if (REG_RVALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("FAIL read data expected none seen %h", REG_RDATA);
      end else begin
        chk("read data", exp_q.pop_front(), REG_RDATA);
      end
    end
  end
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // the whole sequence needs under 1500 cycles
  initial begin
    repeat (5000) @(posedge CLK);
    n_errors++;
    stop_test();
  end
  initial begin
    {RST_N, AUTO_DRAIN_ON_DETACH, FORCED_DRAIN, VBUS_BELOW_SAFE_ZERO, CABLE_POWER_OVERCURRENT,
      TX_REQUEST, TX_BUF_EMPTY, RSVD_BIT_WRITE, DEFAULTS_RESTORED, ATTACH_FOUND, ROLE_DRP,
      ROLE_CC1, ROLE_CC2} = '0;
    {FAULT_MASK, ALERT_MASK_FAULT} = 9'h1ff;
    n_errors = 0;
    checked = 0;
    void'($urandom(32'he192));
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    RST_N = 1'b1;
    repeat (2) @(negedge CLK);
    chk("int pin", 8'h00, {7'h00, int_n});
    chk("int level", 8'h00, {7'h00, INT_N_O});
    rd(8'h1f, 8'h80);
    rd(8'h24, 8'hd8);
    rd(8'h23, 8'h00);
    mgr.acc(1'b1, 8'h24, 8'hff);
    mgr.acc(1'b1, 8'h1f, 8'h00);
    mgr.acc(1'b1, 8'h30, 8'hff);
    rd(8'h24, 8'hd8);
    rd(8'h1f, 8'h80);
    rd(8'h30, 8'h00);
    mgr.clear_all(8'h80);
    repeat (2) @(negedge CLK);
    chk("int pin", 8'h01, {7'h00, int_n});
    // each fault source other than discharge under random masks; unsupported bits must stay clear
    for (int k = 0; k < 5; k++) begin
      @(negedge CLK);
      {FAULT_MASK, ALERT_MASK_FAULT} = 9'($urandom);
      TX_BUF_EMPTY = (k == 1);
      case (k)
        0: CABLE_POWER_OVERCURRENT = 1'b1;
        1, 2: TX_REQUEST = 1'b1;
        3: RSVD_BIT_WRITE = 1'b1;
        default: DEFAULTS_RESTORED = 1'b1;
      endcase
      e = (k == 0) ? 8'h02 : (k == 4) ? 8'h80 : (k == 2) ? 8'h00 : 8'h01;
      @(negedge CLK);
      {CABLE_POWER_OVERCURRENT, TX_REQUEST, RSVD_BIT_WRITE, DEFAULTS_RESTORED} = 4'h0;
      @(negedge CLK);
      chk("alert", {7'h00, e != 8'h00}, {7'h00, ALERT_FAULT});
      chk("int pin", {7'h00, !(ALERT_MASK_FAULT && |(e & FAULT_MASK))}, {7'h00, int_n});
      rd(8'h1f, e);
      mgr.clear_all(e);
    end
    // discharge: auto, forced, then a bus that does reach zero in time
    for (int d = 0; d < 3; d++) begin
      @(negedge CLK);
      {AUTO_DRAIN_ON_DETACH, FORCED_DRAIN, VBUS_BELOW_SAFE_ZERO} =
        (d == 1) ? 3'b010 : (d == 0) ? 3'b100 : 3'b101;
      repeat (SZ + 5) @(negedge CLK);
      {AUTO_DRAIN_ON_DETACH, FORCED_DRAIN, VBUS_BELOW_SAFE_ZERO} = 3'b000;
      e = (d == 0) ? 8'h20 : (d == 1) ? 8'h10 : 8'h00;
      rd(8'h1f, e);
      mgr.clear_all(e);
    end
    // seek command under each role setting, then a stray code
    for (int c = 0; c < 5; c++) begin
      @(negedge CLK);
      ROLE_DRP = (c != 3);
      ROLE_CC1 = (c == 1) ? 2'h2 : 2'h1;
      ROLE_CC2 = (c == 2) ? 2'h2 : ROLE_CC1;
      code = (c < 4) ? 8'h99 : {1'b0, 7'($urandom)};
      mgr.acc(1'b1, 8'h23, code);
      @(negedge CLK);
      chk("seek start", {7'h00, c < 2}, {7'h00, SEEK_START});
      chk("seek active", {7'h00, c < 2}, {7'h00, SEEK_ACTIVE});
      chk("pull-up", {7'h00, c == 0}, {7'h00, SEEK_START_PULLUP && c < 2});
      rd(8'h23, 8'h00);
      ATTACH_FOUND = 1'b1;
      @(negedge CLK);
      ATTACH_FOUND = 1'b0;
    end
    repeat (2) @(negedge CLK);
    stop_test();
  end
endmodule

// File: verilog/pfcr_drain_watch.sv
`timescale 1ns/1ps
// ****************************************************************
// watches a discharge for reaching the safe zero level in time
// ****************************************************************
module pfcr_drain_watch
  import pfcr_pkg::*;
#(
  parameter int LIMIT = SAFE_ZERO_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // discharge enabled and bus below safe zero level
  input wire logic enable,
  input wire logic below_safe,
  // one-cycle pulse when the discharge missed its time
  output logic fail_pulse
);
  import pfcr_pkg::*;

  logic [DRAIN_CNT_W-1:0] cnt_r;
  logic done_r;

  // the counter restarts on every new discharge attempt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      fail_pulse <= 1'b0;
    end else if (!enable || below_safe) begin
      cnt_r <= '0;
      done_r <= 1'b0;
      fail_pulse <= 1'b0;
    end else if (!done_r && cnt_r == DRAIN_CNT_W'(LIMIT - 1)) begin
      done_r <= 1'b1; // one report per attempt
      fail_pulse <= 1'b1;
    end else begin
      cnt_r <= done_r ? cnt_r : cnt_r + 1'b1;
      fail_pulse <= 1'b0;
    end
  end
endmodule

// File: verilog/pfcr_fault_latch.sv
`timescale 1ns/1ps
// ****************************************************************
// one sticky fault bit, write-one-to-clear
// ****************************************************************
module pfcr_fault_latch #(
  parameter logic RESET_VAL = 1'b0,
  parameter logic SUPPORTED = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // set event and software clear
  input wire logic set_evt,
  input wire logic clr_w1,
  // latched bit
  output logic q
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (SUPPORTED && set_evt) begin
      q <= 1'b1;
    end else if (clr_w1) begin
      q <= 1'b0;
    end
  end
endmodule

// File: verilog/pfcr_pkg.sv
// ****************************************************************
// shared constants of the fault, command and capability registers
// ****************************************************************
package pfcr_pkg;
  // register port widths
  localparam int REG_W = 8;
  // register addresses
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h1f;
  localparam logic [7:0] ADDR_COMMAND = 8'h23;
  localparam logic [7:0] ADDR_CAPABILITY_ZERO = 8'h24;
  // fault status bit positions
  localparam int FLT_DEFAULTS_RESTORED = 7;
  localparam int FLT_AUTO_DRAIN_FAILED = 5;
  localparam int FLT_FORCED_DRAIN_FAILED = 4;
  localparam int FLT_CABLE_POWER_OVERCURRENT = 1;
  localparam int FLT_BUS_ERROR = 0;
  // reset value and set of bits that hardware can ever raise
  localparam logic [7:0] FAULT_RESET = 8'h80;
  localparam logic [7:0] FAULT_SUPPORTED = 8'hb3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // command codes
  localparam logic [7:0] CMD_SEEK_ATTACH = 8'h99;
  // termination field encodings of the role control register
  localparam logic [1:0] CC_PULLUP = 2'h1;
  localparam logic [1:0] CC_PULLDOWN = 2'h2;
  // capability byte zero fields
  localparam logic [2:0] CAP_ROLES = 3'h6;
  localparam logic CAP_DEBUG_PACKET_SUPPORT = 1'b1;
  localparam logic CAP_CABLE_POWER_SWITCH = 1'b1;
  localparam logic [2:0] CAP_LOW_BITS = 3'h0;
  localparam logic [7:0] CAP_ZERO_VALUE = {
    CAP_ROLES, CAP_DEBUG_PACKET_SUPPORT, CAP_CABLE_POWER_SWITCH, CAP_LOW_BITS};
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SAFE_ZERO_TIME_MS = 650;
  localparam int SAFE_ZERO_CYCLES = SAFE_ZERO_TIME_MS * (CLK_HZ / 1000);
  localparam int DRAIN_CNT_W = 32;
  // command handling states
  typedef enum logic {
    CMD_IDLE,
    CMD_EXEC
  } pfcr_cmd_state_type;
endpackage

// File: verilog/pfcr_regs.sv
`timescale 1ns/1ps
module pfcr_regs
  import pfcr_pkg::*;
#(
  parameter int SAFE_ZERO_CNT = SAFE_ZERO_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port from the serial interface
  input wire logic [pfcr_pkg::REG_W-1:0] REG_ADDR,
  input wire logic [pfcr_pkg::REG_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [pfcr_pkg::REG_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  // state of neighbouring alert, mask and control registers
  input wire logic [pfcr_pkg::REG_W-1:0] FAULT_MASK,
  input wire logic ALERT_MASK_FAULT,
  input wire logic ALERT_FAULT_WR1,
  input wire logic ROLE_DRP,
  input wire logic [1:0] ROLE_CC1,
  input wire logic [1:0] ROLE_CC2,
  input wire logic AUTO_DRAIN_ON_DETACH,
  input wire logic FORCED_DRAIN,
  // fault sources
  input wire logic VBUS_BELOW_SAFE_ZERO,
  input wire logic CABLE_POWER_OVERCURRENT,
  input wire logic TX_REQUEST,
  input wire logic TX_BUF_EMPTY,
  input wire logic RSVD_BIT_WRITE,
  input wire logic DEFAULTS_RESTORED,
  // connection search feedback
  input wire logic ATTACH_FOUND,
  // alert flag and open-drain interrupt
  output logic ALERT_FAULT,
  output logic INT_N_O,
  output logic INT_N_OE,
  // connection search control
  output logic SEEK_START,
  output logic SEEK_ACTIVE,
  output logic SEEK_START_PULLUP
);
  import pfcr_pkg::*;

  // ****************************************************************
  // register port decode
  // ****************************************************************

  logic wr_fault;
  logic wr_command;
  logic [REG_W-1:0] fault_clr;

  // address matches for the two writable registers
  assign wr_fault = REG_WR && (REG_ADDR == ADDR_FAULT_STATUS);
  assign wr_command = REG_WR && (REG_ADDR == ADDR_COMMAND);

  // only ones written clear; zeros do nothing
  assign fault_clr = wr_fault ? REG_WDATA : ZERO_BYTE;

  // ****************************************************************
  // fault event sources
  // ****************************************************************

  logic auto_fail;
  logic forced_fail;
  logic ocp_prev_r;
  logic ocp_rise;
  logic bus_err;
  logic [REG_W-1:0] fault_set;

  // each discharge mode has its own watch so that both can report
  // in the same attempt; the two share the bus level comparator.
  // a watch reports once per attempt, so a bus that never drains
  // does not flood the status register with repeated events
  // auto discharge on detach watch
  pfcr_drain_watch #(
    .LIMIT(SAFE_ZERO_CNT)
  ) u_auto_watch (
    .clk(CLK),
    .rst_n(RST_N),
    .enable(AUTO_DRAIN_ON_DETACH),
    .below_safe(VBUS_BELOW_SAFE_ZERO),
    .fail_pulse(auto_fail)
  );

  // forced discharge watch
  pfcr_drain_watch #(
    .LIMIT(SAFE_ZERO_CNT)
  ) u_forced_watch (
    .clk(CLK),
    .rst_n(RST_N),
    .enable(FORCED_DRAIN),
    .below_safe(VBUS_BELOW_SAFE_ZERO),
    .fail_pulse(forced_fail)
  );

  // overcurrent is latched on its rising edge so a clear sticks
  // while the detector output is still high
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ocp_prev_r <= 1'b0;
    end else begin
      ocp_prev_r <= CABLE_POWER_OVERCURRENT;
    end
  end

  assign ocp_rise = CABLE_POWER_OVERCURRENT && !ocp_prev_r;

  // transmit with nothing to send, or a reserved bit written nonzero
  assign bus_err = (TX_REQUEST && TX_BUF_EMPTY) || RSVD_BIT_WRITE;

  // set vector; unsupported positions stay zero
  always_comb begin
    fault_set = ZERO_BYTE;
    fault_set[FLT_DEFAULTS_RESTORED] = DEFAULTS_RESTORED;
    fault_set[FLT_AUTO_DRAIN_FAILED] = auto_fail;
    fault_set[FLT_FORCED_DRAIN_FAILED] = forced_fail;
    fault_set[FLT_CABLE_POWER_OVERCURRENT] = ocp_rise;
    fault_set[FLT_BUS_ERROR] = bus_err;
  end

  // ****************************************************************
  // fault status latches
  // ****************************************************************

  logic [REG_W-1:0] fault_r;

  // one sticky bit per position; bit seven comes up set
  // unsupported positions are built as plain zero flops so that a
  // write of ones there reads back zero; the tool trims them anyway.
  // a clear and a new event in one cycle keep the bit set, so the
  // manager always sees a fault that arrived during its clear
  genvar gi;
  generate
    for (gi = 0; gi < REG_W; gi++) begin : g_fault
      pfcr_fault_latch #(
        .RESET_VAL(FAULT_RESET[gi]),
        .SUPPORTED(FAULT_SUPPORTED[gi])
      ) u_bit (
        .clk(CLK),
        .rst_n(RST_N),
        .set_evt(fault_set[gi]),
        .clr_w1(fault_clr[gi]),
        .q(fault_r[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // alert fault flag
  // ****************************************************************

  logic any_fault_set;

  // the flag is a summary of fresh events, not of the status level:
  // a stale bit left set after a premature clear does not raise it
  // again, which is why the clear order is the manager's duty
  // any new fault this cycle raises the alert flag
  assign any_fault_set = |(fault_set & FAULT_SUPPORTED);

  // set wins over the manager's clear in the same cycle; the manager
  // is expected to empty the status register before clearing here
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALERT_FAULT <= 1'b1; // defaults-restored bit is up after reset
    end else if (any_fault_set) begin
      ALERT_FAULT <= 1'b1;
    end else if (ALERT_FAULT_WR1) begin
      ALERT_FAULT <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt pin
  // ****************************************************************

  logic int_want;

  // the pin is shared with other alert sources outside this block;
  // here only the fault contribution is produced and the owner of the
  // pin combines it with the rest
  // drive low only for a set, unmasked fault with the alert unmasked
  assign int_want = ALERT_MASK_FAULT && ALERT_FAULT
                    && |(fault_r & FAULT_MASK);

  // open drain: the pin level is always low, only the enable moves;
  // one cycle of latency keeps the pin free of decode glitches
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      INT_N_OE <= 1'b0;
      INT_N_O <= 1'b0;
    end else begin
      INT_N_OE <= int_want;
      INT_N_O <= 1'b0;
    end
  end

  // ****************************************************************
  // command register
  // ****************************************************************

  pfcr_cmd_state_type cmd_state_r;
  pfcr_cmd_state_type cmd_state_nxt;
  logic [REG_W-1:0] command_r;
  logic seek_ok;
  logic cc_pullup;
  logic cc_pulldown;

  // the register is a one-shot mailbox: the code is kept for a single
  // cycle so a read right after the write sees it, then it returns to
  // zero whether or not it was understood. mixed termination fields
  // leave the port where it is rather than guess a starting role
  // both termination fields must agree on the starting role
  assign cc_pullup = (ROLE_CC1 == CC_PULLUP) && (ROLE_CC2 == CC_PULLUP);
  assign cc_pulldown = (ROLE_CC1 == CC_PULLDOWN)
                       && (ROLE_CC2 == CC_PULLDOWN);

  // the seek command is acted on only for a dual-role port
  assign seek_ok = (command_r == CMD_SEEK_ATTACH) && ROLE_DRP
                   && (cc_pullup || cc_pulldown);

  // a written command is held one cycle, then executed
  always_comb begin
    case (cmd_state_r)
      CMD_IDLE: begin
        cmd_state_nxt = wr_command ? CMD_EXEC : CMD_IDLE;
      end
      CMD_EXEC: begin
        cmd_state_nxt = wr_command ? CMD_EXEC : CMD_IDLE;
      end
      default: begin
        cmd_state_nxt = CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_state_r <= CMD_IDLE;
    end else begin
      cmd_state_r <= cmd_state_nxt;
    end
  end

  // any code is stored; it returns to zero after its one cycle in the execute state, acted upon or not
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      command_r <= ZERO_BYTE;
    end else if (wr_command) begin
      command_r <= REG_WDATA;
    end else if (cmd_state_r == CMD_EXEC) begin
      command_r <= ZERO_BYTE;
    end
  end

  // ****************************************************************
  // connection search control
  // ****************************************************************

  logic seek_go;

  // the start pulse is what the toggle engine listens to; the active
  // level is only a status for the manager and ends on any attach,
  // so a limitation is that a seek cannot be cancelled from here
  // codes other than the seek code fall through with no effect
  assign seek_go = (cmd_state_r == CMD_EXEC) && seek_ok;

  // a repeated seek restarts toggling even while already active
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SEEK_START <= 1'b0;
      SEEK_ACTIVE <= 1'b0;
      SEEK_START_PULLUP <= 1'b0;
    end else if (seek_go) begin
      SEEK_START <= 1'b1;
      SEEK_ACTIVE <= 1'b1;
      SEEK_START_PULLUP <= cc_pullup;
    end else begin
      SEEK_START <= 1'b0;
      if (ATTACH_FOUND) begin
        SEEK_ACTIVE <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************

  logic [REG_W-1:0] rd_mux;

  // capability byte is a constant, unmapped addresses read zero
  always_comb begin
    case (REG_ADDR)
      ADDR_FAULT_STATUS: begin
        rd_mux = fault_r;
      end
      ADDR_COMMAND: begin
        rd_mux = command_r;
      end
      ADDR_CAPABILITY_ZERO: begin
        rd_mux = CAP_ZERO_VALUE;
      end
      default: begin
        rd_mux = ZERO_BYTE;
      end
    endcase
  end

  // read data appears the cycle after the request and then holds
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= ZERO_BYTE;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rd_mux;
      end
    end
  end

endmodule
